// ---- hw/dsw_pkg.sv ----
// Purpose: Shared constants and types of the default start watchdog
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes: Shortest period exponents of main clock and subclock are module parameters of the top
package dsw_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] DSW_MODE_ADDR = 32'hFFFFF6D0;
    localparam logic [31:0] DSW_KICK_ADDR = 32'hFFFFF6D4;
    localparam logic [31:0] DSW_STAT_ADDR = 32'hFFFFF6D8;

    // ************************************************************
    // Reset values and key codes
    // ************************************************************
    localparam logic [7:0] DSW_MODE_RESET = 8'h67;
    localparam logic [7:0] DSW_KICK_RESET = 8'h9A;
    localparam logic [7:0] DSW_KICK_KEY = 8'hAC;
    localparam logic [7:0] DSW_MODE_UNUSED = 8'h1F;

    // ************************************************************
    // Field positions of the mode register
    // ************************************************************
    localparam int DSW_ACT_HI_POS = 6;
    localparam int DSW_ACT_LO_POS = 5;
    localparam int DSW_PER_STOP_POS = 4;
    localparam int DSW_PER_SUB_POS = 3;
    localparam int DSW_PER_EXP_MSB = 2;

    // ************************************************************
    // Period exponents of the shortest code per source
    // ************************************************************
    localparam int DSW_MAIN_EXP_MIN = 18;
    localparam int DSW_SUB_EXP_MIN = 9;
    localparam int DSW_EXP_STEPS = 7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        DSW_ACT_STOP,
        DSW_ACT_NMI,
        DSW_ACT_RESET
    } dsw_action_type;

    typedef enum logic {
        DSW_ST_DEFAULT,
        DSW_ST_LOCKED
    } dsw_state_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } dsw_bus_req_type;

    typedef struct packed {
        logic reset_req;
        logic nmi_req;
    } dsw_req_type;

endpackage : dsw_pkg

// ---- hw/dsw_tick_src.sv ----
// Purpose: Count enable of the watchdog from main clock or subclock
// Assumes: Subclock input is synchronous to clk_sys
// Notes: One enable per subclock rising edge when subclock is chosen
module dsw_tick_src (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sub_clk,
    input wire logic sel_sub,
    input wire logic run,
    output logic tick
);
    import dsw_pkg::*;

    // ************************************************************
    // Subclock edge detect
    // ************************************************************
    logic sub_prev_reg;
    wire logic sub_rise;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sub_prev_reg <= 1'b0;
        end else begin
            sub_prev_reg <= sub_clk;
        end
    end

    assign sub_rise = sub_clk & ~sub_prev_reg;

    // ************************************************************
    // Enable select
    // ************************************************************
    assign tick = run & (sel_sub ? sub_rise : 1'b1);

endmodule // dsw_tick_src

// ---- hw/dsw_watchdog.sv ----
// Purpose: Default start watchdog with write-once mode register
// Assumes: Single clock clk_sys, synchronous active low reset
// Notes: Requests are one-cycle pulses toward reset and NMI logic

// Notes on behaviour
// - Mode register takes one write after reset; reads are always free.
// - Mode register resets to 67H: reset action, longest main period.
// - A second mode write forces the overflow request at once.
// - Action bits 6:5: 00 stop, 01 NMI request, 1x reset request.
// - Period codes 00000 to 00111 give 2^18 to 2^25 main cycles.
// - Codes 01000 to 01111 give 2^9 to 2^16 subclock cycles; bit4 stops.
// - Writing 1FH as the single write leaves the watchdog stopped.
// - Writing key ACH to the kick register clears and restarts the count.
// - Kick register resets to 9AH.
// - Counting starts by itself after reset in reset action.
// - Period elapsed without a kick raises reset or NMI per action.
// - Once configured to run, nothing stops the counter until reset.
module dsw_watchdog #(
    parameter int MAIN_EXP_MIN = dsw_pkg::DSW_MAIN_EXP_MIN,
    parameter int SUB_EXP_MIN = dsw_pkg::DSW_SUB_EXP_MIN
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input dsw_pkg::dsw_bus_req_type bus_req,
    output logic [7:0] rd_data,
    input wire logic sub_clk,
    output logic wd_reset_request,
    output logic wd_nmi_request
);
    import dsw_pkg::*;

    localparam int CNT_W = MAIN_EXP_MIN + DSW_EXP_STEPS;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] wd_mode_reg;
    logic [7:0] wd_mode_next;
    logic [7:0] wd_kick_reg;
    logic [7:0] wd_kick_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    dsw_state_type state_reg;
    dsw_state_type state_next;
    dsw_req_type req_reg;
    dsw_req_type req_next;
    dsw_action_type action;

    wire logic hit_mode;
    wire logic hit_kick;
    wire logic hit_stat;
    wire logic mode_wr;
    wire logic kick_wr;
    wire logic key_ok;
    wire logic first_wr;
    wire logic second_wr;
    wire logic wd_action_hi;
    wire logic wd_action_lo;
    wire logic wd_period_sel4;
    wire logic wd_period_sel3;
    wire logic [2:0] period_exp;
    wire logic [5:0] exp_base;
    wire logic [5:0] exp_sel;
    wire logic [CNT_W-1:0] cnt_limit;
    wire logic run;
    wire logic tick;
    wire logic terminal;
    wire logic overflow;
    wire logic fire;
    wire logic [7:0] stat_value;

    // ************************************************************
    // Address decode
    // ************************************************************
    assign hit_mode = (bus_req.addr == DSW_MODE_ADDR);
    assign hit_kick = (bus_req.addr == DSW_KICK_ADDR);
    assign hit_stat = (bus_req.addr == DSW_STAT_ADDR);
    assign mode_wr = bus_req.we & hit_mode;
    assign kick_wr = bus_req.we & hit_kick;
    assign key_ok = kick_wr & (bus_req.wdata == DSW_KICK_KEY);
    assign first_wr = mode_wr & (state_reg == DSW_ST_DEFAULT);
    assign second_wr = mode_wr & (state_reg == DSW_ST_LOCKED);

    // ************************************************************
    // Mode fields
    // ************************************************************
    assign wd_action_hi = wd_mode_reg[DSW_ACT_HI_POS];
    assign wd_action_lo = wd_mode_reg[DSW_ACT_LO_POS];
    assign wd_period_sel4 = wd_mode_reg[DSW_PER_STOP_POS];
    assign wd_period_sel3 = wd_mode_reg[DSW_PER_SUB_POS];
    assign period_exp = wd_mode_reg[DSW_PER_EXP_MSB:0];

    always_comb begin
        if (wd_action_hi) begin
            action = DSW_ACT_RESET;
        end else if (wd_action_lo) begin
            action = DSW_ACT_NMI;
        end else begin
            action = DSW_ACT_STOP;
        end
    end

    // ************************************************************
    // Period select
    // ************************************************************
    assign exp_base = wd_period_sel3 ? 6'(SUB_EXP_MIN) : 6'(MAIN_EXP_MIN);
    assign exp_sel = exp_base + {3'h0, period_exp};
    assign cnt_limit = (CNT_W'(1) << exp_sel) - CNT_W'(1);

    // Stop action or stop code freezes the counter
    assign run = (action != DSW_ACT_STOP) & ~wd_period_sel4;

    dsw_tick_src u_tick_src (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sub_clk(sub_clk),
        .sel_sub(wd_period_sel3),
        .run(run),
        .tick(tick)
    );

    // ************************************************************
    // Counter and overflow
    // ************************************************************
    assign terminal = (cnt_reg == cnt_limit);
    assign overflow = tick & terminal & ~key_ok;
    assign fire = overflow | second_wr;

    always_comb begin
        if (key_ok) begin
            cnt_next = '0;
        end else if (tick && terminal) begin
            cnt_next = '0;
        end else if (tick) begin
            cnt_next = cnt_reg + CNT_W'(1);
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_comb begin
        req_next.reset_req = fire & (action != DSW_ACT_NMI);
        req_next.nmi_req = fire & (action == DSW_ACT_NMI);
    end

    // ************************************************************
    // Write-once state and registers
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DSW_ST_DEFAULT: begin
                if (mode_wr) begin
                    state_next = DSW_ST_LOCKED;
                end
            end
            DSW_ST_LOCKED: begin
                state_next = DSW_ST_LOCKED;
            end
            default: begin
                state_next = DSW_ST_LOCKED;
            end
        endcase
    end

    assign wd_mode_next = first_wr ? {1'b0, bus_req.wdata[6:0]}
                                   : wd_mode_reg;
    assign wd_kick_next = kick_wr ? bus_req.wdata : wd_kick_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= DSW_ST_DEFAULT;
            wd_mode_reg <= DSW_MODE_RESET;
            wd_kick_reg <= DSW_KICK_RESET;
        end else begin
            state_reg <= state_next;
            wd_mode_reg <= wd_mode_next;
            wd_kick_reg <= wd_kick_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            req_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            req_reg <= req_next;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    assign stat_value = {5'h00, wd_period_sel3, run,
                         (state_reg == DSW_ST_LOCKED)};

    always_comb begin
        rd_data_next = 8'h00;
        if (bus_req.re) begin
            if (hit_mode) begin
                rd_data_next = wd_mode_reg;
            end else if (hit_kick) begin
                rd_data_next = wd_kick_reg;
            end else if (hit_stat) begin
                rd_data_next = stat_value;
            end else begin
                rd_data_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign wd_reset_request = req_reg.reset_req;
    assign wd_nmi_request = req_reg.nmi_req;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_MODE_RESET: assert property (
        $rose(rst_n) |-> wd_mode_reg == DSW_MODE_RESET)
        else $error("mode register not 67H after reset");

    AST_KICK_RESET: assert property (
        $rose(rst_n) |-> wd_kick_reg == DSW_KICK_RESET)
        else $error("kick register not 9AH after reset");

    AST_AUTO_START: assert property (
        $rose(rst_n) && !key_ok |=> cnt_reg == CNT_W'(1))
        else $error("counter did not start after reset");

    AST_FIRST_WRITE: assert property (
        first_wr |=> wd_mode_reg == {1'b0, $past(bus_req.wdata[6:0])}
                     && state_reg == DSW_ST_LOCKED)
        else $error("first mode write not taken");

    AST_WRITE_ONCE: assert property (
        second_wr |=> $stable(wd_mode_reg))
        else $error("mode register changed on second write");

    AST_FORCED_OVF: assert property (
        second_wr |=> (wd_reset_request || wd_nmi_request))
        else $error("second mode write did not force overflow");

    AST_NMI_SEL: assert property (
        wd_nmi_request |-> !wd_reset_request
                           && $past(wd_mode_reg[6:5]) == 2'b01)
        else $error("NMI request under wrong action");

    AST_KICK_CLEAR: assert property (
        key_ok |=> cnt_reg == '0 && !wd_reset_request && !wd_nmi_request
                   || $past(second_wr))
        else $error("key write did not clear counter");

    AST_HOLD_STOP: assert property (
        !run && !key_ok |=> $stable(cnt_reg)
                            && (!wd_reset_request && !wd_nmi_request
                                || $past(second_wr)))
        else $error("counter moved while stopped");

    AST_OVERFLOW: assert property (
        overflow |=> cnt_reg == '0 && (wd_reset_request ^ wd_nmi_request))
        else $error("overflow did not raise one request");

    AST_LIMIT: assert property (
        run && !wd_period_sel3 && tick |-> cnt_limit ==
            ({CNT_W{1'b1}} >> (CNT_W - MAIN_EXP_MIN - int'(period_exp))))
        else $error("main period limit wrong");

    AST_LOCKED_RUN: assert property (
        state_reg == DSW_ST_LOCKED && run |=> run)
        else $error("running watchdog stopped after lock");

    AST_SUB_LIMIT: assert property (
        run && wd_period_sel3 && tick |-> cnt_limit ==
            ({CNT_W{1'b1}} >> (CNT_W - SUB_EXP_MIN - int'(period_exp))))
        else $error("subclock period limit wrong");

    AST_MODE_READ: assert property (
        bus_req.re && hit_mode |=> rd_data == $past(wd_mode_reg))
        else $error("mode register read wrong");

    AST_KICK_READ: assert property (
        bus_req.re && hit_kick |=> rd_data == $past(wd_kick_reg))
        else $error("kick register read wrong");

    AST_KICK_STORE: assert property (
        kick_wr |=> wd_kick_reg == $past(bus_req.wdata))
        else $error("kick register did not take written byte");

    AST_STOP_UNUSED: assert property (
        wd_mode_reg == DSW_MODE_UNUSED && !second_wr
            |=> !wd_reset_request && !wd_nmi_request)
        else $error("request while set to unused");

    AST_RESET_SEL: assert property (
        wd_reset_request |-> !wd_nmi_request
            && ($past(wd_mode_reg[DSW_ACT_HI_POS]) || $past(second_wr)))
        else $error("reset request under wrong action");

    AST_DEFAULT_RUN: assert property (
        state_reg == DSW_ST_DEFAULT |-> run && !wd_period_sel3)
        else $error("default configuration not running on main clock");

    AST_MAIN_TICK: assert property (
        run && !wd_period_sel3 |-> tick)
        else $error("main clock step missing");

    AST_SUB_TICK: assert property (
        run && wd_period_sel3 |-> tick == $rose(sub_clk))
        else $error("subclock step not on its rising edge");

    AST_COUNT_STEP: assert property (
        tick && !terminal && !key_ok
            |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
        else $error("counter did not step by one");

    COV_RESET_OVF: cover property (overflow && action == DSW_ACT_RESET);
    COV_NMI_OVF: cover property (overflow && action == DSW_ACT_NMI);
    COV_FORCED: cover property (second_wr);
    COV_SUB_TICK: cover property (tick && wd_period_sel3);
    COV_KICK_MID: cover property (key_ok && cnt_reg != '0);

endmodule // dsw_watchdog

// ---- verification/dsw_testbench.sv ----
// Purpose: Self-checking bench of the default start watchdog
// Assumes: Shortened period exponents, subclock made by the bench
// Notes: Each mode case starts from a fresh reset, the mode is write-once
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dsw_pkg::*;

    // ************************************************************
    // Clock, reset and stimulus signals
    // ************************************************************
    localparam int MAIN_MIN = 4;
    localparam int SUB_MIN = 2;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sub_div = 2'h0;
    dsw_bus_req_type bus_req = '0;
    logic [7:0] rd_data;
    logic wd_reset_request;
    logic wd_nmi_request;
    wire logic sub_clk = sub_div[1];
    int err_count = 0;
    int comparisons = 0;

    always #25 clk_sys = ~clk_sys;

    // Subclock rises once every four system clocks
    always @(posedge clk_sys) begin
        sub_div <= sub_div + 2'h1;
    end

    dsw_watchdog #(.MAIN_EXP_MIN(MAIN_MIN), .SUB_EXP_MIN(SUB_MIN)) DUT (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .sub_clk(sub_clk),
        .wd_reset_request(wd_reset_request),
        .wd_nmi_request(wd_nmi_request)
    );

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Bus and sequence tasks
    // ************************************************************
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.we <= 1'b1;
        @(posedge clk_sys);
        bus_req.we <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a,
                          input logic [7:0] exp);
        bus_req.addr <= a;
        bus_req.re <= 1'b1;
        @(posedge clk_sys);
        bus_req.re <= 1'b0;
        #1;
        check(name, 32'(rd_data), 32'(exp));
    endtask

    // Waits for a request; kind is {reset, nmi}, 00 means none by hi
    task automatic expect_req(input string name, input logic [1:0] kind,
                              input int lo, input int hi);
        int n;
        n = 0;
        while (wd_reset_request !== 1'b1 && wd_nmi_request !== 1'b1
               && n <= hi) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(name, 32'({wd_reset_request, wd_nmi_request}), 32'(kind));
        if (kind != 2'b00) begin
            check(name, 32'(n >= lo && n <= hi), 32'h1);
            @(posedge clk_sys);
            #1;
            check(name, 32'({wd_reset_request, wd_nmi_request}), 32'h0);
        end
    endtask

    task automatic run_case(input logic [7:0] mode, input logic [1:0] kind,
                            input int lo, input int hi);
        do_reset();
        wr(DSW_MODE_ADDR, mode);
        rd_chk("mode readback", DSW_MODE_ADDR, {1'b0, mode[6:0]});
        wr(DSW_KICK_ADDR, DSW_KICK_KEY);
        expect_req("overflow", kind, lo, hi);
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        int p;
        logic [1:0] act;
        do_reset();
        rd_chk("mode reset", DSW_MODE_ADDR, DSW_MODE_RESET);
        rd_chk("kick reset", DSW_KICK_ADDR, DSW_KICK_RESET);
        rd_chk("unmapped read", 32'hFFFFF6DC, 8'h00);
        wr(32'hFFFFF6DC, 8'h3C);
        wr(DSW_KICK_ADDR, 8'h55);
        rd_chk("kick data", DSW_KICK_ADDR, 8'h55);
        rd_chk("mode after stray", DSW_MODE_ADDR, DSW_MODE_RESET);
        wr(DSW_MODE_ADDR, DSW_MODE_RESET);
        rd_chk("status locked", DSW_STAT_ADDR, 8'h03);
        // Default start with no software action
        do_reset();
        p = 1 << (MAIN_MIN + 7);
        expect_req("default start", 2'b10, p, p);
        // Main clock periods under NMI and reset actions
        for (int c = 0; c < 8; c++) begin
            act = (c % 3 == 0) ? 2'b01 : ((c % 3 == 1) ? 2'b10 : 2'b11);
            p = 1 << (MAIN_MIN + c);
            run_case({1'b0, act, 5'(c)}, (act == 2'b01) ? 2'b01 : 2'b10,
                     p, p);
        end
        // Subclock periods
        for (int c = 0; c < 8; c++) begin
            act = c[0] ? 2'b01 : 2'b11;
            p = 4 * (1 << (SUB_MIN + c));
            run_case({1'b0, act, 5'(8 + c)}, c[0] ? 2'b01 : 2'b10,
                     p - 4, p + 8);
        end
        // Stop settings never overflow
        run_case(8'h00, 2'b00, 0, 300);
        run_case(DSW_MODE_UNUSED, 2'b00, 0, 300);
        run_case(8'h50, 2'b00, 0, 300);
        // Key restarts the count, other bytes do not
        do_reset();
        wr(DSW_MODE_ADDR, 8'h20);
        p = 1 << MAIN_MIN;
        wr(DSW_KICK_ADDR, DSW_KICK_KEY);
        repeat (10) @(posedge clk_sys);
        wr(DSW_KICK_ADDR, DSW_KICK_KEY);
        expect_req("kick restart", 2'b01, p, p);
        wr(DSW_KICK_ADDR, DSW_KICK_KEY);
        wr(DSW_KICK_ADDR, 8'h55);
        expect_req("wrong key", 2'b01, p - 1, p - 1);
        // Later mode writes force an overflow
        wr(DSW_MODE_ADDR, 8'h47);
        expect_req("second write", 2'b01, 0, 0);
        rd_chk("mode kept", DSW_MODE_ADDR, 8'h20);
        wr(DSW_MODE_ADDR, DSW_MODE_UNUSED);
        expect_req("third write", 2'b01, 0, 0);
        expect_req("still running", 2'b01, 1, p);
        do_reset();
        wr(DSW_MODE_ADDR, 8'h00);
        wr(DSW_MODE_ADDR, 8'h00);
        expect_req("forced from stop", 2'b10, 0, 0);
        conclude();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        #1500000;
        err_count++;
        conclude();
    end

endmodule // testbench
